/* rvea_top.sv */
// Reactive energy accumulators, register file and reactive pulse output
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/1ns
`default_nettype none
module rvea_top #(
   parameter int PWR_W = 24,
   parameter int FRAC_W = 12,
   parameter int DFC_THRESH = 1048576,
   parameter int LONG_CYC = rvea_pkg::LONG_PERIOD_CYC,
   parameter int FIXED_CYC = rvea_pkg::FIXED_WIDTH_CYC
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // Register port
   input wire logic [rvea_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [rvea_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [rvea_pkg::DATA_W-1:0] reg_rdata,
   // Filtered products, voltage times shifted current
   input wire logic signed [PWR_W-1:0] pwr_va_ia,
   input wire logic signed [PWR_W-1:0] pwr_va_ib,
   input wire logic signed [PWR_W-1:0] pwr_vb_ib,
   input wire logic signed [PWR_W-1:0] pwr_vc_ic,
   input wire logic signed [PWR_W-1:0] pwr_vc_ib,
   // Per-phase active power sign and total apparent power
   input wire logic [2:0] active_neg,
   input wire logic [PWR_W-1:0] apparent_total,
   // Outputs
   output logic reactive_pulse_output,
   output logic irq_n
);
   import rvea_pkg::*;
   localparam int PW = PWR_W + 1;
   localparam int DW = PW + 2;
   localparam int AW = 34;

   logic rst_q1;
   logic rst_n;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_q1 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_q1 <= 1'b1;
         rst_n <= rst_q1;
      end
   end

   // Software registers
   logic [7:0] reactive_energy_divider;
   logic [7:0] compensation_mode_register;
   logic [7:0] line_cycle_mode_register;
   logic [7:0] waveform_mode_register;
   logic [FRAC_W-1:0] pulse_divider_numerator;
   logic [FRAC_W-1:0] pulse_divider_denominator;
   logic half_full_status;
   logic reactive_half_full_mask;

   logic wr_div, wr_comp, wr_line, wr_wave, wr_num, wr_den;
   logic wr_status, wr_mask;
   assign wr_div = reg_wr && reg_addr == OFS_DIVIDER;
   assign wr_comp = reg_wr && reg_addr == OFS_COMP_MODE;
   assign wr_line = reg_wr && reg_addr == OFS_LINE_MODE;
   assign wr_wave = reg_wr && reg_addr == OFS_WAVE_MODE;
   assign wr_num = reg_wr && reg_addr == OFS_PDIV_NUM;
   assign wr_den = reg_wr && reg_addr == OFS_PDIV_DEN;
   assign wr_status = reg_wr && reg_addr == OFS_STATUS;
   assign wr_mask = reg_wr && reg_addr == OFS_MASK;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reactive_energy_divider <= RST_DIVIDER;
         compensation_mode_register <= RST_COMP_MODE;
         line_cycle_mode_register <= RST_LINE_MODE;
         waveform_mode_register <= RST_WAVE_MODE;
         pulse_divider_numerator <= '0;
         pulse_divider_denominator <= '0;
         reactive_half_full_mask <= 1'b0;
      end else begin
         if (wr_div) begin
            reactive_energy_divider <= reg_wdata[7:0];
         end
         if (wr_comp) begin
            compensation_mode_register <= reg_wdata[7:0];
         end
         if (wr_line) begin
            line_cycle_mode_register <= reg_wdata[7:0];
         end
         if (wr_wave) begin
            waveform_mode_register <= reg_wdata[7:0];
         end
         if (wr_num) begin
            pulse_divider_numerator <= reg_wdata[FRAC_W-1:0];
         end
         if (wr_den) begin
            pulse_divider_denominator <= reg_wdata[FRAC_W-1:0];
         end
         if (wr_mask) begin
            reactive_half_full_mask <= reg_wdata[HF_BIT];
         end
      end
   end

   // Sample strobe, one in every four cycles
   logic [1:0] sample_cnt;
   logic sample_tick;
   assign sample_tick = sample_cnt == 2'(SAMPLE_CYCLES - 1);
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sample_cnt <= '0;
      end else begin
         sample_cnt <= sample_cnt + 2'h1;
      end
   end

   // Accumulator inputs by phase combination
   rvea_comb_t comb;
   logic signed [PW-1:0] phase_in [3];
   logic signed [PW-1:0] diff_a, diff_c;
   assign comb = rvea_comb_t'(compensation_mode_register[COMB_LSB +: 2]);
   assign diff_a = PW'(pwr_va_ia) - PW'(pwr_va_ib);
   assign diff_c = PW'(pwr_vc_ic) - PW'(pwr_vc_ib);
   // Reserved code behaves as the per-phase code
   assign phase_in[0] = (comb == RVEA_COMB_DIFF || comb == RVEA_COMB_MIX) ?
      diff_a : PW'(pwr_va_ia);
   assign phase_in[1] = (comb == RVEA_COMB_DIFF || comb == RVEA_COMB_MIX) ?
      '0 : PW'(pwr_vb_ib);
   assign phase_in[2] = (comb == RVEA_COMB_DIFF) ?
      diff_c : PW'(pwr_vc_ic);

   // Per-phase accumulators
   logic signed [ACC_W-1:0] acc [3];
   logic signed [ACC_W-1:0] acc_sum [3];
   logic signed [PW-1:0] quot [3];
   logic signed [DW-1:0] term [3];
   logic [2:0] rd_clr;
   logic [2:0] hf_evt;
   logic rclr_en;
   logic sign_adj;
   assign rclr_en = line_cycle_mode_register[READ_CLR_BIT];
   assign sign_adj = compensation_mode_register[SIGN_ADJ_BIT];

   for (genvar i = 0; i < 3; i++) begin : g_phase
      rvea_div #(.W(PW)) u_div (
         .power(phase_in[i]),
         .divisor(reactive_energy_divider),
         .quotient(quot[i])
      );
      // Plain two's complement add wraps 0x7FFF/0x8000 in the top bits
      assign acc_sum[i] = acc[i] + ACC_W'(quot[i]);
      assign rd_clr[i] = reg_rd && rclr_en &&
         reg_addr == OFS_ENERGY_A + ADDR_W'(i);
      assign hf_evt[i] = sample_tick && !rd_clr[i] &&
         acc_sum[i][HALF_BIT] != acc[i][HALF_BIT];
      assign term[i] = !compensation_mode_register[TERM_LSB + i] ? '0 :
         (sign_adj && active_neg[i]) ? -DW'(phase_in[i]) :
         DW'(phase_in[i]);
      // A clearing read wins over the sample landing in the same cycle
      always_ff @(posedge core_clk or negedge rst_n) begin
         if (!rst_n) begin
            acc[i] <= '0;
         end else if (rd_clr[i]) begin
            acc[i] <= '0;
         end else if (sample_tick) begin
            acc[i] <= acc_sum[i];
         end
      end
   end

   // Half-full flag and interrupt, set beats a write-one clear
   logic next_half_full;
   assign next_half_full = |hf_evt ||
      (half_full_status && !(wr_status && reg_wdata[HF_BIT]));
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         half_full_status <= 1'b0;
         irq_n <= 1'b1;
      end else begin
         half_full_status <= next_half_full;
         irq_n <= !(half_full_status && reactive_half_full_mask);
      end
   end

   // Read port, data valid only in the cycle after the strobe
   logic [DATA_W-1:0] rd_mux;
   assign rd_mux =
      reg_addr == OFS_ENERGY_A ? acc[0][VIS_LSB +: DATA_W] :
      reg_addr == OFS_ENERGY_B ? acc[1][VIS_LSB +: DATA_W] :
      reg_addr == OFS_ENERGY_C ? acc[2][VIS_LSB +: DATA_W] :
      reg_addr == OFS_DIVIDER ? {8'h00, reactive_energy_divider} :
      reg_addr == OFS_COMP_MODE ? {8'h00, compensation_mode_register} :
      reg_addr == OFS_LINE_MODE ? {8'h00, line_cycle_mode_register} :
      reg_addr == OFS_WAVE_MODE ? {8'h00, waveform_mode_register} :
      reg_addr == OFS_PDIV_NUM ? DATA_W'(pulse_divider_numerator) :
      reg_addr == OFS_PDIV_DEN ? DATA_W'(pulse_divider_denominator) :
      reg_addr == OFS_STATUS ? DATA_W'({half_full_status, 1'b0}) :
      reg_addr == OFS_MASK ? DATA_W'({reactive_half_full_mask, 1'b0}) :
      16'h0000;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : '0;
      end
   end

   // Digital-to-frequency converter on the magnitude of the total, or of apparent_total when APPARENT_BIT is set
   logic signed [DW-1:0] total;
   logic signed [DW-1:0] dfc_in;
   logic [DW-1:0] dfc_mag;
   logic [AW-1:0] dfc_acc, dfc_sum;
   logic dfc_hit;
   logic dfc_pulse;
   assign total = term[0] + term[1] + term[2];
   assign dfc_in = waveform_mode_register[APPARENT_BIT] ?
      DW'($signed({1'b0, apparent_total})) : total;
   assign dfc_mag = dfc_in[DW-1] ? DW'(-dfc_in) : DW'(dfc_in);
   assign dfc_sum = dfc_acc + AW'(dfc_mag);
   assign dfc_hit = dfc_sum >= AW'(DFC_THRESH);
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         dfc_acc <= '0;
         dfc_pulse <= 1'b0;
      end else begin
         dfc_pulse <= sample_tick && dfc_hit;
         if (sample_tick) begin
            dfc_acc <= dfc_hit ? dfc_sum - AW'(DFC_THRESH) : dfc_sum;
         end
      end
   end

   rvea_pulse #(
      .FRAC_W(FRAC_W),
      .LONG_CYC(LONG_CYC),
      .FIXED_CYC(FIXED_CYC)
   ) u_pulse (
      .clk(core_clk),
      .rst_n(rst_n),
      .dfc_pulse(dfc_pulse),
      .num(pulse_divider_numerator),
      .den(pulse_divider_denominator),
      .pulse_out(reactive_pulse_output)
   );

   // Checks
   sequence s_quiet3;
      !sample_tick [*3];
   endsequence
   property p_sample_period;
      @(posedge core_clk) disable iff (!rst_n)
      sample_tick |=> s_quiet3 ##1 sample_tick;
   endproperty
   a_sample_period: assert property (p_sample_period)
      else $error("sample period is not four cycles");

   property p_acc_step;
      @(posedge core_clk) disable iff (!rst_n)
      sample_tick && !rd_clr[0] |=>
         acc[0] == $past(acc[0]) + ACC_W'($past(quot[0]));
   endproperty
   a_acc_step: assert property (p_acc_step)
      else $error("accumulator step wrong");

   property p_no_div;
      @(posedge core_clk) disable iff (!rst_n)
      reactive_energy_divider <= 8'h01 |-> quot[0] == phase_in[0];
   endproperty
   a_no_div: assert property (p_no_div)
      else $error("divider 0 or 1 still divides");

   property p_read_vis;
      @(posedge core_clk) disable iff (!rst_n)
      reg_rd && reg_addr == OFS_ENERGY_B |=>
         reg_rdata == $past(acc[1][VIS_LSB +: DATA_W]);
   endproperty
   a_read_vis: assert property (p_read_vis)
      else $error("energy read not upper 16 bits");

   property p_read_clear;
      @(posedge core_clk) disable iff (!rst_n)
      reg_rd && rclr_en && reg_addr == OFS_ENERGY_C |=> acc[2] == '0;
   endproperty
   a_read_clear: assert property (p_read_clear)
      else $error("read with clear left energy");

   property p_wrap;
      @(posedge core_clk) disable iff (!rst_n)
      sample_tick && !rd_clr[0] && acc[0][ACC_W-1 -: 16] == 16'h7FFF &&
         acc_sum[0][ACC_W-1] |=> acc[0][ACC_W-1 -: 16] == 16'h8000;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("positive overflow did not wrap to 0x8000");

   property p_hf_irq;
      @(posedge core_clk) disable iff (!rst_n)
      |hf_evt && reactive_half_full_mask && !wr_mask |=>
         half_full_status ##1 !irq_n;
   endproperty
   a_hf_irq: assert property (p_hf_irq)
      else $error("half-full did not raise interrupt");

   property p_apparent;
      @(posedge core_clk) disable iff (!rst_n)
      waveform_mode_register[APPARENT_BIT] |->
         dfc_mag == DW'(apparent_total);
   endproperty
   a_apparent: assert property (p_apparent)
      else $error("converter not fed apparent power");

   property p_wrap_neg;
      @(posedge core_clk) disable iff (!rst_n)
      sample_tick && !rd_clr[0] && acc[0][ACC_W-1 -: 16] == 16'h8000 &&
         !acc_sum[0][ACC_W-1] |=> acc[0][ACC_W-1 -: 16] == 16'h7FFF;
   endproperty
   a_wrap_neg: assert property (p_wrap_neg)
      else $error("negative overflow did not wrap to 0x7FFF");

   property p_irq_on;
      @(posedge core_clk) disable iff (!rst_n)
      half_full_status && reactive_half_full_mask |=> !irq_n;
   endproperty
   a_irq_on: assert property (p_irq_on)
      else $error("unmasked half-full flag left interrupt idle");

   property p_irq_off;
      @(posedge core_clk) disable iff (!rst_n)
      !half_full_status |=> irq_n;
   endproperty
   a_irq_off: assert property (p_irq_off)
      else $error("interrupt active without half-full flag");

   // Both difference codes leave phase B with nothing to integrate
   property p_comb_b;
      @(posedge core_clk) disable iff (!rst_n)
      (comb == RVEA_COMB_DIFF || comb == RVEA_COMB_MIX) |->
         phase_in[1] == '0;
   endproperty
   a_comb_b: assert property (p_comb_b)
      else $error("phase B input not zero in difference mode");

   property p_rdata_idle;
      @(posedge core_clk) disable iff (!rst_n)
      !reg_rd |=> reg_rdata == '0;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data present without a read");
endmodule
`default_nettype wire

/* rvea_pkg.sv */
// Constants shared by the reactive energy accumulator and its pulse output
package rvea_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam int ACC_W = 41;
   localparam int VIS_LSB = 25;
   localparam int HALF_BIT = VIS_LSB + 14;
   localparam int SAMPLE_CYCLES = 4;
   localparam int PULSE_EQ_CYC = 64;
   localparam int CLK_HZ = 50_000_000;
   localparam int LONG_PERIOD_MS = 180;
   localparam int FIXED_WIDTH_MS = 90;
   localparam int LONG_PERIOD_CYC = CLK_HZ / 1000 * LONG_PERIOD_MS;
   localparam int FIXED_WIDTH_CYC = CLK_HZ / 1000 * FIXED_WIDTH_MS;
   // Register offsets
   localparam logic [ADDR_W-1:0] OFS_ENERGY_A = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_ENERGY_B = 4'h1;
   localparam logic [ADDR_W-1:0] OFS_ENERGY_C = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_DIVIDER = 4'h3;
   localparam logic [ADDR_W-1:0] OFS_COMP_MODE = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_LINE_MODE = 4'h5;
   localparam logic [ADDR_W-1:0] OFS_WAVE_MODE = 4'h6;
   localparam logic [ADDR_W-1:0] OFS_PDIV_NUM = 4'h7;
   localparam logic [ADDR_W-1:0] OFS_PDIV_DEN = 4'h8;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h9;
   localparam logic [ADDR_W-1:0] OFS_MASK = 4'hA;
   // Field positions
   localparam int COMB_LSB = 0;
   localparam int TERM_LSB = 2;
   localparam int ABS_BIT = 5;
   localparam int SIGN_ADJ_BIT = 6;
   localparam int READ_CLR_BIT = 6;
   localparam int APPARENT_BIT = 7;
   localparam int HF_BIT = 1;
   // Reset values
   localparam logic [7:0] RST_DIVIDER = 8'h00;
   localparam logic [7:0] RST_COMP_MODE = 8'h1C;
   localparam logic [7:0] RST_LINE_MODE = 8'h00;
   localparam logic [7:0] RST_WAVE_MODE = 8'h00;
   // Phase combination codes
   typedef enum logic [1:0] {
      RVEA_COMB_EACH = 2'h0,
      RVEA_COMB_DIFF = 2'h1,
      RVEA_COMB_MIX = 2'h2,
      RVEA_COMB_RSVD = 2'h3
   } rvea_comb_t;
endpackage

/* rvea_div.sv */
// Signed power divided by an unsigned 8-bit divisor
`timescale 1ns/1ns
`default_nettype none
module rvea_div #(
   parameter int W = 25
) (
   // Operands
   input wire logic signed [W-1:0] power,
   input wire logic [7:0] divisor,
   // Result
   output logic signed [W-1:0] quotient
);
   import rvea_pkg::*;
   logic no_div;
   logic signed [W:0] wide_div;
   logic signed [W:0] wide_q;
   assign no_div = divisor <= 8'h01;
   assign wide_div = $signed({{(W - 7){1'b0}}, divisor});
   // Truncates toward zero, so the sign of the step never flips
   assign wide_q = no_div ? '0 : (W + 1)'(power) / wide_div;
   assign quotient = no_div ? power : W'(wide_q);
endmodule
`default_nettype wire

/* rvea_pulse.sv */
// Output pulse divider and pulse width generator
`timescale 1ns/1ns
`default_nettype none
module rvea_pulse #(
   parameter int FRAC_W = 12,
   parameter int LONG_CYC = rvea_pkg::LONG_PERIOD_CYC,
   parameter int FIXED_CYC = rvea_pkg::FIXED_WIDTH_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Converter pulses and ratio
   input wire logic dfc_pulse,
   input wire logic [FRAC_W-1:0] num,
   input wire logic [FRAC_W-1:0] den,
   // Output
   output logic pulse_out
);
   import rvea_pkg::*;
   localparam int CW = 32;
   logic [FRAC_W-1:0] num_eff, den_eff;
   logic [FRAC_W:0] frac, frac_sum, half_den;
   logic [CW-1:0] gap, dfc_period, out_gap, out_period, hi_cnt;
   logic [CW-1:0] width, next_hi_cnt;
   logic [CW+FRAC_W:0] prod;
   logic fire, long_case;
   assign num_eff = (num == '0) ? FRAC_W'(1) : num;
   assign den_eff = (den == '0) ? FRAC_W'(1) : den;
   assign frac_sum = frac + {1'b0, num_eff};
   assign fire = dfc_pulse && (frac_sum >= {1'b0, den_eff});
   assign half_den = ({1'b0, den_eff} + (FRAC_W + 1)'(1)) >> 1;
   assign prod = dfc_period * half_den;
   assign long_case = out_period > CW'(LONG_CYC);
   assign width = long_case ? CW'(FIXED_CYC) :
      (den_eff > num_eff) ?
      ((prod > (CW + FRAC_W + 1)'(32'hFFFFFFFF)) ? 32'hFFFFFFFF : CW'(prod)) :
      CW'(PULSE_EQ_CYC);
   assign next_hi_cnt = fire ? width :
      (hi_cnt != '0) ? hi_cnt - CW'(1) : '0;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         frac <= '0;
         gap <= '0;
         dfc_period <= '0;
         out_gap <= '0;
         out_period <= '0;
         hi_cnt <= '0;
         pulse_out <= 1'b0;
      end else begin
         if (dfc_pulse) begin
            frac <= fire ? frac_sum - {1'b0, den_eff} : frac_sum;
         end
         gap <= dfc_pulse ? '0 : (&gap ? gap : gap + CW'(1));
         if (dfc_pulse) begin
            dfc_period <= gap + CW'(1);
         end
         out_gap <= fire ? '0 : (&out_gap ? out_gap : out_gap + CW'(1));
         if (fire) begin
            out_period <= out_gap + CW'(1);
         end
         hi_cnt <= next_hi_cnt;
         pulse_out <= next_hi_cnt != '0;
      end
   end
   property p_width_eq;
      @(posedge clk) disable iff (!rst_n)
      fire && !long_case && num_eff == den_eff |=>
         pulse_out && hi_cnt == 32'h00000040;
   endproperty
   a_width_eq: assert property (p_width_eq)
      else $error("equal ratio pulse width not 64");
   property p_width_long;
      @(posedge clk) disable iff (!rst_n)
      fire && long_case |=> hi_cnt == CW'(FIXED_CYC);
   endproperty
   a_width_long: assert property (p_width_long)
      else $error("long period width not fixed");
endmodule
`default_nettype wire

/* rvea_pulse_counter.sv */
// Pulse counter model measuring width and period of the pulse output
`timescale 1ns/1ns
`default_nettype none
module rvea_pulse_counter (
   // Clock
   input wire logic clk,
   // Watched pulse line
   input wire logic pulse,
   // Fall count, and width and period in clock cycles
   output var int n_fall,
   output var int width,
   output var int period
);
   int hi_cnt = 0;
   int gap = 0;
   int n_fall_q = 0;
   int width_q = 0;
   int period_q = 0;
   logic last = 1'b0;
   assign n_fall = n_fall_q;
   assign width = width_q;
   assign period = period_q;
   // A counter only sees whole pulses, so width updates on the fall
   always @(posedge clk) begin
      last <= pulse;
      hi_cnt <= pulse ? hi_cnt + 1 : 0;
      gap <= (pulse && !last) ? 1 : gap + 1;
      if (pulse && !last)
         period_q <= gap;
      if (!pulse && last) begin
         width_q <= hi_cnt;
         n_fall_q <= n_fall_q + 1;
      end
   end
endmodule
`default_nettype wire

/* rvea_top_tb.sv */
// Self-checking bench for the reactive energy accumulator
`timescale 1ns/1ns
`default_nettype none
module rvea_top_tb;
   import rvea_pkg::*;
   localparam int LC = 400;
   localparam int FC = 200;
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [DATA_W-1:0] reg_wdata = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [DATA_W-1:0] reg_rdata;
   logic signed [23:0] pwr_va_ia = '0;
   logic signed [23:0] pwr_va_ib = '0;
   logic signed [23:0] pwr_vb_ib = '0;
   logic signed [23:0] pwr_vc_ic = '0;
   logic signed [23:0] pwr_vc_ib = '0;
   logic [2:0] active_neg = '0;
   logic [23:0] apparent_total = '0;
   logic reactive_pulse_output;
   logic irq_n;
   int n_fall, width, period, nf;
   int n_mismatch = 0;
   int samples_checked = 0;
   logic [15:0] rv, ea, eb, ec;
   logic [3:0] ra [8] = '{OFS_DIVIDER, OFS_COMP_MODE, OFS_LINE_MODE,
      OFS_WAVE_MODE, OFS_PDIV_NUM, OFS_PDIV_DEN, OFS_STATUS, 4'hF};
   logic [15:0] rvl [8] = '{1: 16'h001C, default: 16'h0000};
   logic [15:0] dv [4] = '{16'h0000, 16'h0001, 16'h0003, 16'h00FF};
   logic [15:0] de [4] = '{16'h0007, 16'h0007, 16'h0002, 16'h0000};
   logic [15:0] ca [4] = '{16'h0007, 16'h0003, 16'h0003, 16'h0007};
   logic [15:0] cb [4] = '{16'h0002, 16'h0000, 16'h0000, 16'h0002};
   logic [15:0] cc [4] = '{16'h0007, 16'h0003, 16'h0007, 16'h0007};
   logic [15:0] pd [3] = '{16'h0001, 16'h0003, 16'h0004};
   int pp [3] = '{128, 384, 512};
   int pwd [3] = '{PULSE_EQ_CYC, 256, FC};

   rvea_top #(.DFC_THRESH(64), .LONG_CYC(LC), .FIXED_CYC(FC)) dut (
      .core_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .pwr_va_ia, .pwr_va_ib, .pwr_vb_ib, .pwr_vc_ic,
      .pwr_vc_ib, .active_neg, .apparent_total, .reactive_pulse_output,
      .irq_n);
   rvea_pulse_counter cnt (.clk(core_clk), .pulse(reactive_pulse_output),
      .n_fall, .width, .period);

   initial begin
      forever #10 core_clk = ~core_clk;
   end

   task automatic chk(input string nm, input logic [31:0] got,
         input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %0h seen %0h", nm, exp, got);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      rv = reg_rdata;
   endtask

   task automatic pw(input logic [23:0] a, ab, b, c, cb);
      @(posedge core_clk);
      pwr_va_ia <= a;
      pwr_va_ib <= ab;
      pwr_vb_ib <= b;
      pwr_vc_ic <= c;
      pwr_vc_ib <= cb;
   endtask

   // Powers are picked so one sample more or less keeps the same word
   task automatic meas();
      rd(OFS_ENERGY_A);
      rd(OFS_ENERGY_B);
      rd(OFS_ENERGY_C);
      repeat (316) @(posedge core_clk);
      rd(OFS_ENERGY_A);
      ea = rv;
      rd(OFS_ENERGY_B);
      eb = rv;
      rd(OFS_ENERGY_C);
      ec = rv;
   endtask

   task automatic falls(input int n);
      int f0;
      int t;
      f0 = n_fall;
      t = 0;
      while (n_fall < f0 + n && t < 5000) begin
         @(posedge core_clk);
         t++;
      end
      if (t >= 5000) begin
         n_mismatch++;
         $display("unexpected pulse wait: timed out");
         stop_test();
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      repeat (5) @(posedge core_clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      chk("irq_n", irq_n, 1'b1);
      for (int i = 0; i < 8; i++) begin
         rd(ra[i]);
         chk("reset value", rv, rvl[i]);
      end
      $display("test reset done");
      // Phase sum off so the converter stays quiet meanwhile
      wr(OFS_COMP_MODE, 16'h0000);
      wr(OFS_LINE_MODE, 16'h0040);
      pw(24'h300000, 24'h180000, 24'h100000, 24'h300000, 24'h180000);
      for (int i = 0; i < 4; i++) begin
         wr(OFS_DIVIDER, dv[i]);
         meas();
         chk("energy a", ea, de[i]);
      end
      $display("test divider done");
      wr(OFS_DIVIDER, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         wr(OFS_COMP_MODE, 16'(i));
         meas();
         chk("energy a", ea, ca[i]);
         chk("energy b", eb, cb[i]);
         chk("energy c", ec, cc[i]);
      end
      $display("test combination done");
      wr(OFS_COMP_MODE, 16'h0000);
      wr(OFS_STATUS, 16'h0002);
      pw(24'hD00000, 24'h0, 24'h0, 24'h0, 24'h0);
      meas();
      chk("energy a", ea, 16'hFFF8);
      pw(24'h0, 24'h0, 24'h0, 24'h0, 24'h0);
      rd(OFS_ENERGY_A);
      rd(OFS_ENERGY_A);
      chk("cleared energy", rv, 16'h0000);
      rd(OFS_STATUS);
      chk("status", rv, 16'h0002);
      chk("irq_n masked", irq_n, 1'b1);
      wr(OFS_MASK, 16'h0002);
      repeat (2) @(negedge core_clk);
      chk("irq_n", irq_n, 1'b0);
      wr(OFS_STATUS, 16'h0002);
      repeat (2) @(negedge core_clk);
      chk("irq_n cleared", irq_n, 1'b1);
      // Unmasked event this time: first negative sample flips bit 14
      pw(24'hD00000, 24'h0, 24'h0, 24'h0, 24'h0);
      repeat (8) @(negedge core_clk);
      chk("irq_n event", irq_n, 1'b0);
      pw(24'h0, 24'h0, 24'h0, 24'h0, 24'h0);
      $display("test half full done");
      wr(OFS_COMP_MODE, 16'h0014);
      pw(24'h000001, 24'h0, 24'h0, 24'hFFFFFF, 24'h0);
      active_neg <= 3'b100;
      repeat (200) @(posedge core_clk);
      nf = n_fall;
      repeat (600) @(posedge core_clk);
      chk("pulse count", n_fall, nf);
      wr(OFS_COMP_MODE, 16'h0074);
      // Second pulse still sees the idle stretch as its period, so skip it
      falls(4);
      chk("period", period, 128);
      chk("width", width, PULSE_EQ_CYC);
      $display("test sign adjust done");
      wr(OFS_COMP_MODE, 16'h0014);
      wr(OFS_WAVE_MODE, 16'h0080);
      apparent_total <= 24'h000002;
      for (int i = 0; i < 3; i++) begin
         wr(OFS_PDIV_DEN, pd[i]);
         falls(3);
         chk("period", period, pp[i]);
         chk("width", width, pwd[i]);
      end
      $display("test pulse output done");
      stop_test();
   end
endmodule
`default_nettype wire
